// ===== nsp_pkg.sv
// constants for the nonvolatile self-program controller
//==========================================================
// Notes on behaviour
// RQ1: config select steers accesses to user ID, device ID and config words.
// RQ2: config 8000h-8003h read/write; 8006h-8008h read only.
// RQ3: config read outside permitted set clears both data registers.
// RQ4: low data register holds EEPROM byte or program word bits 7-0.
// RQ5: high data register holds word bits 13-8; bits 7-6 read zero.
// RQ6: low address register gives address bits 7-0, resets to zero.
// RQ7: high address register gives bits 14-8; bit 7 reads one.
// RQ8: control bit 7 selects program Flash when set, EEPROM when clear.
// RQ9: control bit 6 selects config space, overriding bit 7.
// RQ10: latch-only set: write strobe only loads the addressed latch.
// RQ11: latch-only clear: load latch then program the whole latch block.
// RQ12: for EEPROM latch-only is ignored; every strobe writes the byte.
// RQ13: erase select makes next strobe a row erase, cleared on finish.
// RQ14: for EEPROM erase select ignored; strobe does erase then write.
// RQ15: error flag set on any write strobe attempt; clear means normal end.
// RQ16: write enable clear blocks all programming and erasing.
// RQ17: write strobe set-only by software, cleared by hardware at end.
// RQ18: read strobe set-only; read takes one cycle, then hardware clears.
// RQ19: software does read-modify-erase-reprogram to change part of a row.
// RQ20: software may read back to verify written values.
// RQ21: unlock needs 55h then AAh at the key port before write strobe.
// RQ22: processor stalls during array write or erase, not latch loads.
// RQ23: 32-word latch block is written wholly on a block write.
// RQ24: strobe without fresh unlock or with enable clear starts nothing.
package nsp_pkg;
   //==========================================================
   // register offsets
   localparam logic [2:0] NSP_OFS_DATL = 3'h0;
   localparam logic [2:0] NSP_OFS_DATH = 3'h1;
   localparam logic [2:0] NSP_OFS_ADRL = 3'h2;
   localparam logic [2:0] NSP_OFS_ADRH = 3'h3;
   localparam logic [2:0] NSP_OFS_CTL = 3'h4;
   localparam logic [2:0] NSP_OFS_KEY = 3'h5;
   //==========================================================
   // control fields
   localparam int NSP_B_PGD = 7;
   localparam int NSP_B_CFG = 6;
   localparam int NSP_B_LATCH_ONLY = 5;
   localparam int NSP_B_FREE = 4;
   localparam int NSP_B_ERR = 3;
   localparam int NSP_B_ALLOW = 2;
   localparam int NSP_B_WR = 1;
   localparam int NSP_B_RD = 0;
   localparam logic [7:0] NSP_KEY_A = 8'h55;
   localparam logic [7:0] NSP_KEY_B = 8'hAA;
   //==========================================================
   // reset values and config map
   localparam logic [7:0] NSP_ADRL_RST = 8'h00;
   localparam logic [6:0] NSP_ADRH_RST = 7'h00;
   localparam logic [14:0] NSP_UID_LAST = 15'h0003;
   localparam logic [14:0] NSP_DEVID = 15'h0006;
   localparam logic [14:0] NSP_CFGW_LAST = 15'h0008;
   localparam int NSP_LATCHES = 32;
   //==========================================================
   // timing
   localparam int NSP_CLK_NS = 40;
   localparam int NSP_PROG_NS = 2000000;
   localparam int NSP_PROG_CYC = NSP_PROG_NS / NSP_CLK_NS;
   //==========================================================
   // types
   typedef enum logic [4:0] {
      NSP_IDLE = 5'h01,
      NSP_READ = 5'h02,
      NSP_LATCH = 5'h04,
      NSP_STREAM = 5'h08,
      NSP_TIMED = 5'h10
   } nsp_state_t;
   typedef enum logic [2:0] {
      NSP_K_NONE = 3'h1,
      NSP_K_HALF = 3'h2,
      NSP_K_ARMED = 3'h4
   } nsp_key_t;
   typedef enum logic [1:0] {
      NSP_SP_EE = 2'h0,
      NSP_SP_FLASH = 2'h1,
      NSP_SP_CFG = 2'h2
   } nsp_space_t;
endpackage

// ===== nsp_ctrl.sv
// register-driven read/erase/program controller for flash, eeprom and config
`timescale 1ns/10ps
`default_nettype none
module nsp_ctrl #(
   parameter int PROG_CYCLES = nsp_pkg::NSP_PROG_CYC
) (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic [2:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [13:0] arr_rdata_in,
   output logic arr_rd_en_out,
   output logic arr_wr_en_out,
   output logic arr_erase_out,
   output nsp_pkg::nsp_space_t arr_space_out,
   output logic [14:0] arr_addr_out,
   output logic [13:0] arr_wdata_out,
   output logic cpu_stall_out
);
   import nsp_pkg::*;

   //==========================================================
   // state
   nsp_state_t st_q;
   nsp_key_t key_q;
   logic [7:0] datl_q;
   logic [5:0] dath_q;
   logic [7:0] adrl_q;
   logic [6:0] adrh_q;
   logic pgd_q, cfg_q, lonly_q, free_q, err_q, allow_q, wr_q, rd_q;
   logic op_erase_q;
   logic [15:0] tmr_q;
   logic [4:0] idx_q;
   logic [13:0] latch_q [NSP_LATCHES];

   //==========================================================
   // config address checks
   function automatic logic cfg_rd_ok(input logic [14:0] a);
      cfg_rd_ok = (a <= NSP_UID_LAST) || (a >= NSP_DEVID && a <= NSP_CFGW_LAST);
   endfunction
   function automatic logic cfg_wr_ok(input logic [14:0] a);
      cfg_wr_ok = (a <= NSP_UID_LAST);
   endfunction

   //==========================================================
   // decode
   wire [7:0] w = reg_wdata_in;
   wire idle = (st_q == NSP_IDLE);
   wire wr_datl = reg_wr_in && reg_addr_in == NSP_OFS_DATL;
   wire wr_dath = reg_wr_in && reg_addr_in == NSP_OFS_DATH;
   wire wr_adrl = reg_wr_in && reg_addr_in == NSP_OFS_ADRL;
   wire wr_adrh = reg_wr_in && reg_addr_in == NSP_OFS_ADRH;
   wire wr_ctl = reg_wr_in && reg_addr_in == NSP_OFS_CTL;
   wire wr_key = reg_wr_in && reg_addr_in == NSP_OFS_KEY;
   wire [14:0] addr = {adrh_q, adrl_q}; // RQ6 RQ7
   wire n_pgd = wr_ctl ? w[NSP_B_PGD] : pgd_q;
   wire n_cfg = wr_ctl ? w[NSP_B_CFG] : cfg_q;
   wire n_lonly = wr_ctl ? w[NSP_B_LATCH_ONLY] : lonly_q;
   wire n_free = wr_ctl ? w[NSP_B_FREE] : free_q;
   wire n_allow = wr_ctl ? w[NSP_B_ALLOW] : allow_q;
   // config overrides memory select
   wire flash_like = n_cfg | n_pgd; // RQ8 RQ9
   nsp_space_t n_space;
   assign n_space = n_cfg ? NSP_SP_CFG : (n_pgd ? NSP_SP_FLASH : NSP_SP_EE); // RQ1 RQ9
   wire wr_try = wr_ctl && w[NSP_B_WR] && idle;
   // refused strobes start nothing and leave the error flag up
   wire wr_ok = wr_try && key_q == NSP_K_ARMED && n_allow
                && (!n_cfg || cfg_wr_ok(addr)); // RQ16 RQ21 RQ24 RQ2
   wire rd_go = wr_ctl && w[NSP_B_RD] && idle && !wr_try;
   wire rd_legal = !cfg_q || cfg_rd_ok(addr); // RQ2 RQ3
   wire op_latch = wr_ok && flash_like && !n_free && n_lonly; // RQ10
   wire op_block = wr_ok && flash_like && !n_free && !n_lonly; // RQ11
   wire op_erase = wr_ok && flash_like && n_free; // RQ13
   wire op_ee = wr_ok && !flash_like; // RQ12 RQ14
   wire tmr_done = st_q == NSP_TIMED && tmr_q == 16'h0000;
   wire stream_last = st_q == NSP_STREAM && idx_q == 5'h1F;
   wire [7:0] ctl_rd = {pgd_q, cfg_q, lonly_q, free_q, err_q, allow_q, wr_q, rd_q};
   logic [7:0] rd_mux;
   assign rd_mux = (reg_addr_in == NSP_OFS_DATL) ? datl_q :
                   (reg_addr_in == NSP_OFS_DATH) ? {2'b00, dath_q} : // RQ5
                   (reg_addr_in == NSP_OFS_ADRL) ? adrl_q :
                   (reg_addr_in == NSP_OFS_ADRH) ? {1'b1, adrh_q} : // RQ7
                   (reg_addr_in == NSP_OFS_CTL) ? ctl_rd : 8'h00;

   //==========================================================
   // register read port
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rd_mux;
      end
   end

   //==========================================================
   // unlock sequence: any other write breaks it
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         key_q <= NSP_K_NONE;
      end else if (wr_key && w == NSP_KEY_A) begin
         key_q <= NSP_K_HALF; // RQ21
      end else if (wr_key && w == NSP_KEY_B && key_q == NSP_K_HALF) begin
         key_q <= NSP_K_ARMED; // RQ21
      end else if (reg_wr_in) begin
         key_q <= NSP_K_NONE; // RQ24
      end
   end

   //==========================================================
   // address and data registers
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         adrl_q <= NSP_ADRL_RST; // RQ6
         adrh_q <= NSP_ADRH_RST;
      end else begin
         if (wr_adrl) begin
            adrl_q <= w;
         end
         if (wr_adrh) begin
            adrh_q <= w[6:0];
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         datl_q <= 8'h00;
         dath_q <= 6'h00;
      end else if (st_q == NSP_READ) begin
         // illegal config read returns zero, not array content
         datl_q <= rd_legal ? arr_rdata_in[7:0] : 8'h00; // RQ3 RQ4
         dath_q <= rd_legal ? arr_rdata_in[13:8] : 6'h00; // RQ3 RQ5
      end else begin
         if (wr_datl) begin
            datl_q <= w; // RQ4
         end
         if (wr_dath) begin
            dath_q <= w[5:0]; // RQ5
         end
      end
   end

   //==========================================================
   // write latches: no reset, whole block always programmed
   always_ff @(posedge sys_clk_in) begin
      if (op_latch || op_block) begin
         latch_q[adrl_q[4:0]] <= {dath_q, datl_q}; // RQ10 RQ11
      end
   end

   //==========================================================
   // control register
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         {pgd_q, cfg_q, lonly_q, allow_q} <= 4'h0;
      end else if (wr_ctl) begin
         pgd_q <= w[NSP_B_PGD];
         cfg_q <= w[NSP_B_CFG];
         lonly_q <= w[NSP_B_LATCH_ONLY];
         allow_q <= w[NSP_B_ALLOW];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         free_q <= 1'b0;
      end else if (wr_ctl) begin
         free_q <= w[NSP_B_FREE];
      end else if (tmr_done && op_erase_q && arr_space_out != NSP_SP_EE) begin
         free_q <= 1'b0; // RQ13
      end
   end

   // a set attempt wins over the clear at normal completion
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         err_q <= 1'b0;
      end else if (wr_ctl && w[NSP_B_WR]) begin
         err_q <= 1'b1; // RQ15
      end else if (wr_ctl) begin
         err_q <= w[NSP_B_ERR];
      end else if (tmr_done || st_q == NSP_LATCH) begin
         err_q <= 1'b0; // RQ15
      end
   end

   // strobes: software can only set them
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         if (wr_ok) begin
            wr_q <= 1'b1; // RQ17
         end else if (tmr_done || st_q == NSP_LATCH) begin
            wr_q <= 1'b0; // RQ17
         end
         if (rd_go) begin
            rd_q <= 1'b1; // RQ18
         end else if (st_q == NSP_READ) begin
            rd_q <= 1'b0; // RQ18
         end
      end
   end

   //==========================================================
   // sequencer
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         st_q <= NSP_IDLE;
      end else begin
         case (st_q)
            NSP_IDLE: begin
               if (op_latch) begin
                  st_q <= NSP_LATCH; // RQ10
               end else if (op_block) begin
                  st_q <= NSP_STREAM; // RQ11
               end else if (op_erase || op_ee) begin
                  st_q <= NSP_TIMED; // RQ13 RQ14
               end else if (rd_go) begin
                  st_q <= NSP_READ; // RQ18
               end
            end
            NSP_READ: st_q <= NSP_IDLE;
            NSP_LATCH: st_q <= NSP_IDLE;
            NSP_STREAM: begin
               if (stream_last) begin
                  st_q <= NSP_TIMED; // RQ23
               end
            end
            NSP_TIMED: begin
               if (tmr_done) begin
                  st_q <= NSP_IDLE;
               end
            end
            default: st_q <= NSP_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         tmr_q <= 16'h0000;
         idx_q <= 5'h00;
         op_erase_q <= 1'b0;
      end else begin
         if (op_erase || op_ee || stream_last) begin
            tmr_q <= 16'(PROG_CYCLES - 1); // RQ22
         end else if (st_q == NSP_TIMED && tmr_q != 16'h0000) begin
            tmr_q <= tmr_q - 16'h0001;
         end
         if (op_block) begin
            idx_q <= 5'h00;
         end else if (st_q == NSP_STREAM) begin
            idx_q <= idx_q + 5'h01;
         end
         if (wr_ok) begin
            op_erase_q <= op_erase || op_ee;
         end
      end
   end

   //==========================================================
   // array side
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         arr_rd_en_out <= 1'b0;
         arr_wr_en_out <= 1'b0;
         arr_erase_out <= 1'b0;
         arr_space_out <= NSP_SP_EE;
         arr_addr_out <= 15'h0000;
         arr_wdata_out <= 14'h0000;
      end else begin
         arr_rd_en_out <= rd_go && (!n_cfg || cfg_rd_ok(addr)); // RQ3
         // eeprom issues erase and write together: erase first, then byte
         arr_wr_en_out <= op_ee || st_q == NSP_STREAM; // RQ14 RQ23
         arr_erase_out <= op_erase || op_ee; // RQ13 RQ14
         if (rd_go || wr_ok) begin
            arr_space_out <= n_space; // RQ1
            arr_addr_out <= addr;
            arr_wdata_out <= {6'h00, datl_q}; // RQ4
         end else if (st_q == NSP_STREAM) begin
            arr_addr_out <= {arr_addr_out[14:5], idx_q};
            arr_wdata_out <= latch_q[idx_q]; // RQ23
         end
      end
   end

   // stall only on real array work, never on a latch load
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         cpu_stall_out <= 1'b0;
      end else begin
         cpu_stall_out <= op_block || op_erase || op_ee
                          || (st_q == NSP_STREAM)
                          || (st_q == NSP_TIMED && !tmr_done); // RQ22
      end
   end
endmodule // nsp_ctrl
`default_nettype wire

// ===== nsp_ctrl_assertions.sv
// port-level checks for the nvm controller
`timescale 1ns/10ps
`default_nettype none
module nsp_ctrl_assertions #(
   parameter int PROG_CYCLES = nsp_pkg::NSP_PROG_CYC
) (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic [2:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [13:0] arr_rdata_in,
   input wire logic arr_rd_en_out,
   input wire logic arr_wr_en_out,
   input wire logic arr_erase_out,
   input wire nsp_pkg::nsp_space_t arr_space_out,
   input wire logic [14:0] arr_addr_out,
   input wire logic [13:0] arr_wdata_out,
   input wire logic cpu_stall_out
);
   import nsp_pkg::*;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   logic ctl_wr;
   logic aa_q;
   logic blk_q;
   logic [5:0] wcnt_q;
   assign ctl_wr = reg_wr_in && reg_addr_in == NSP_OFS_CTL;
   //==========================================================
   // helpers: last write was the second key, words per busy period
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in || !cpu_stall_out) begin
         wcnt_q <= 6'h00;
      end else if (arr_wr_en_out) begin
         wcnt_q <= wcnt_q + 6'h01;
      end
      if (sys_rst_in) begin
         aa_q <= 1'b0;
      end else if (reg_wr_in) begin
         aa_q <= reg_addr_in == NSP_OFS_KEY && reg_wdata_in == NSP_KEY_B;
      end
      if ($rose(cpu_stall_out)) begin
         blk_q <= !arr_erase_out;
      end
   end
   //==========================================================
   // properties
   sequence s_go;
      ctl_wr && reg_wdata_in[NSP_B_WR] && !cpu_stall_out;
   endsequence
   sequence s_quiet;
      !cpu_stall_out && !arr_wr_en_out && !arr_erase_out;
   endsequence
   a_pulse_has_stall: assert property ((arr_wr_en_out || arr_erase_out) |-> cpu_stall_out)
      else $error("array pulse outside stall");
   a_allow_gate: assert property (s_go ##0 !reg_wdata_in[NSP_B_ALLOW] |=> s_quiet [*2])
      else $error("operation with write enable clear");
   a_needs_key: assert property (s_go ##0 !aa_q |=> s_quiet [*2])
      else $error("operation without unlock");
   a_latch_quiet: assert property (s_go ##0 reg_wdata_in[NSP_B_LATCH_ONLY]
      && (reg_wdata_in[NSP_B_PGD] || reg_wdata_in[NSP_B_CFG]) |=> s_quiet [*2])
      else $error("latch load started array work");
   a_rd_pulse: assert property (ctl_wr && reg_wdata_in[NSP_B_RD] && !reg_wdata_in[NSP_B_WR]
      && !reg_wdata_in[NSP_B_CFG] && !cpu_stall_out |=> arr_rd_en_out ##1 !arr_rd_en_out)
      else $error("read strobe not one cycle");
   a_rd_space: assert property (arr_rd_en_out |-> arr_space_out == ($past(reg_wdata_in[NSP_B_CFG])
      ? NSP_SP_CFG : ($past(reg_wdata_in[NSP_B_PGD]) ? NSP_SP_FLASH : NSP_SP_EE)))
      else $error("read in wrong space");
   a_ee_pair: assert property (arr_wr_en_out && arr_space_out == NSP_SP_EE
      |-> arr_erase_out && arr_wdata_out[13:8] == 6'h00)
      else $error("eeprom write without erase");
   a_busy_bound: assert property ($rose(cpu_stall_out)
      |-> cpu_stall_out [*4] ##[1:1000] !cpu_stall_out)
      else $error("busy period length wrong");
   a_block_words: assert property ($fell(cpu_stall_out) && blk_q |-> wcnt_q == 6'h20)
      else $error("block write word count wrong");
endmodule // nsp_ctrl_assertions
bind nsp_ctrl nsp_ctrl_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_nsp_ctrl_assertions (
   .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .arr_rdata_in(arr_rdata_in), .arr_rd_en_out(arr_rd_en_out),
   .arr_wr_en_out(arr_wr_en_out), .arr_erase_out(arr_erase_out), .arr_space_out(arr_space_out),
   .arr_addr_out(arr_addr_out), .arr_wdata_out(arr_wdata_out), .cpu_stall_out(cpu_stall_out)
);
`default_nettype wire

// ===== tb_nsp_ctrl.sv
// self-checking bench for the nvm controller
`timescale 1ns/10ps
`default_nettype none
module tb_nsp_ctrl;
   import nsp_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pend = 1'b0, ok;
   logic re, we, er, st;
   logic [2:0] ad = 3'h0;
   logic [7:0] wd = 8'h00, rdo, x, y, z;
   logic [13:0] ain = 14'h0000, aw;
   logic [14:0] aa;
   nsp_space_t sp;
   logic [31:0] s = 32'h00000022;
   logic [32:0] g;
   logic [32:0] wq[$];
   logic [7:0] rq[$];
   logic [15:0] rt[7] = '{16'h015A, 16'h81A5, 16'h4103, 16'h4104, 16'h4106, 16'h4108, 16'h4109};
   int bad_count = 0, comparisons = 0;
   always #20 clk = ~clk;
   nsp_ctrl #(.PROG_CYCLES(8)) u_nsp_ctrl (.sys_clk_in(clk), .sys_rst_in(rst),
      .reg_addr_in(ad), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdo),
      .arr_rdata_in(ain), .arr_rd_en_out(re), .arr_wr_en_out(we), .arr_erase_out(er),
      .arr_space_out(sp), .arr_addr_out(aa), .arr_wdata_out(aw), .cpu_stall_out(st));
   assign g = {we, er, sp, aa, aw & {14{we}}};
   //==========================================================
   // helpers
   function automatic logic [7:0] rnd();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s[7:0];
   endfunction
   task automatic chk(input logic [32:0] v, input logic [32:0] e);
      comparisons++;
      if (v !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h want %h", $time, v, e);
      end
   endtask
   task automatic report_and_stop();
      if (bad_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // two edges per access: a strobe is never assigned twice in one step
   task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      ad <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rdx(input logic [2:0] a, input logic [7:0] e);
      rq.push_back(e);
      op(1'b0, a, 8'h00);
   endtask
   task automatic go(input logic [7:0] c);
      op(1'b1, NSP_OFS_KEY, NSP_KEY_A);
      op(1'b1, NSP_OFS_KEY, NSP_KEY_B);
      op(1'b1, NSP_OFS_CTL, c);
   endtask
   task automatic wt();
      int n;
      n = 0;
      @(posedge clk);
      while (st !== 1'b0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) begin
         bad_count++;
         report_and_stop();
      end
   endtask
   //==========================================================
   // result watcher: an array pulse with nothing queued always mismatches
   always @(posedge clk) begin
      pend <= rd;
      if (pend) begin
         chk({25'h0, rdo}, {25'h0, rq.pop_front()});
      end
      if (we || er || re) begin
         chk(g, wq.size() > 0 ? wq.pop_front() : ~g);
      end
   end
   //==========================================================
   // scenarios
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) rdx(3'(i), i == 3 ? 8'h80 : 8'h00);
      x = rnd();
      for (int i = 0; i < 4; i++) begin
         op(1'b1, 3'(i), x);
         rdx(3'(i), i == 1 ? x & 8'h3F : (i == 3 ? x | 8'h80 : x));
      end
      op(1'b1, NSP_OFS_ADRH, 8'h00);
      foreach (rt[i]) begin
         y = rt[i][7:0];
         ok = !rt[i][14] || y < 8'h04 || (y > 8'h05 && y < 8'h09);
         x = rnd();
         z = rnd();
         ain <= {x[5:0], z};
         op(1'b1, NSP_OFS_ADRL, y);
         if (ok) wq.push_back({2'b00, (rt[i][14] ? NSP_SP_CFG : (rt[i][15] ? NSP_SP_FLASH
            : NSP_SP_EE)), 7'h00, y, 14'h0000});
         op(1'b1, NSP_OFS_CTL, rt[i][15:8]);
         rdx(NSP_OFS_DATL, ok ? z : 8'h00);
         rdx(NSP_OFS_DATH, ok ? {2'b00, x[5:0]} : 8'h00);
         rdx(NSP_OFS_CTL, rt[i][15:8] & 8'hFE);
      end
      x = rnd();
      y = rnd();
      op(1'b1, NSP_OFS_DATL, x);
      op(1'b1, NSP_OFS_ADRL, y);
      wq.push_back({2'b11, NSP_SP_EE, 7'h00, y, 6'h00, x});
      go(8'h36);
      wt();
      // software read-back of the byte just written
      ain <= {6'h00, x};
      wq.push_back({2'b00, NSP_SP_EE, 7'h00, y, 14'h0000});
      op(1'b1, NSP_OFS_CTL, 8'h01);
      rdx(NSP_OFS_DATL, x);
      for (int i = 0; i < 4; i++) begin
         z = i == 3 ? 8'hC6 : (i == 0 ? 8'h82 : 8'h86);
         op(1'b1, NSP_OFS_ADRL, 8'h06);
         if (i != 1) op(1'b1, NSP_OFS_KEY, NSP_KEY_A);
         if (i != 1) op(1'b1, NSP_OFS_KEY, NSP_KEY_B);
         if (i == 2) op(1'b1, NSP_OFS_ADRL, 8'h06);
         op(1'b1, NSP_OFS_CTL, z);
         rdx(NSP_OFS_CTL, (z & 8'hFD) | 8'h08);
      end
      x = rnd() & 8'hE0;
      op(1'b1, NSP_OFS_ADRL, x);
      wq.push_back({2'b01, NSP_SP_FLASH, 7'h00, x, 14'h0000});
      go(8'h96);
      wt();
      rdx(NSP_OFS_CTL, 8'h84);
      y = rnd() & 8'hE0;
      x = rnd();
      op(1'b1, NSP_OFS_ADRH, x);
      for (int i = 0; i < 32; i++) begin
         z = rnd();
         op(1'b1, NSP_OFS_ADRL, y | 8'(i));
         op(1'b1, NSP_OFS_DATL, z);
         op(1'b1, NSP_OFS_DATH, z);
         wq.push_back({2'b10, NSP_SP_FLASH, x[6:0], y[7:5], 5'(i), z[5:0], z});
         go(i < 31 ? 8'hA6 : 8'h86);
         wt();
      end
      rdx(NSP_OFS_CTL, 8'h84);
      op(1'b1, NSP_OFS_ADRL, 8'h00);
      chk(33'(wq.size() + rq.size()), 33'h0);
      report_and_stop();
   end
endmodule // tb_nsp_ctrl
`default_nettype wire
